//--- fsrb_regs.vh
`ifndef FSRB_REGS_VH
`define FSRB_REGS_VH
// Byte one positions.
`define FSRB_S1_PM_LO 7
`define FSRB_S1_ORIGIN 6
`define FSRB_S1_BP_HI 5
`define FSRB_S1_BP_LO 2
`define FSRB_S1_WLATCH 1
`define FSRB_S1_BUSY 0
// Byte two positions.
`define FSRB_S2_ERASE_HELD 7
`define FSRB_S2_COMPL 6
`define FSRB_S2_OTP_HI 5
`define FSRB_S2_OTP_LO 3
`define FSRB_S2_PROG_HELD 2
`define FSRB_S2_QUAD 1
`define FSRB_S2_PM_HI 0
// Byte three positions.
`define FSRB_S3_PIN_ROLE 7
`define FSRB_S3_DRV_HI 6
`define FSRB_S3_DRV_LO 5
`define FSRB_S3_ERASE_FAIL 4
`define FSRB_S3_PROG_FAIL 3
`define FSRB_S3_SCHEME 2
`define FSRB_S3_PWRUP_AW 1
`define FSRB_S3_CUR_AW 0
// Writable masks and reset values.
`define FSRB_S1_WMASK 8'hFC
`define FSRB_S2_WMASK 8'h7B
`define FSRB_S3_WMASK 8'hE6
`define FSRB_RESET_VAL 8'h00
// Register select codes.
`define FSRB_SEL_ONE 2'h0
`define FSRB_SEL_TWO 2'h1
`define FSRB_SEL_THREE 2'h2
// Embedded operation time in clock cycles.
`define FSRB_OP_CYCLES 16'h0010
`endif

//--- fsrb_flash_status_regs.v
`timescale 1ns/1ps
`include "fsrb_regs.vh"
// Summary of operation
// - Protect-mode low bit at byte one bit 7.
// - Byte one bit 6 selects protection origin.
// - Block-protect field bits 5:2, zero unprotected.
// - Write latch read-only; gates embedded operations.
// - Busy flag at byte one bit 0.
// - Byte two bit 6 inverts protection map.
// - Three OTP lock bits, byte two 5:3.
// - Program-suspended flag at byte two bit 2.
// - Quad enable turns control pins into data.
// - Protect-mode high bit at byte two bit 0.
// - Byte three bit 7 picks pin role.
// - Erase-fail flag set on failure or violation.
// - Program-fail flag set on failure or violation.
// - Byte three bit 2 selects protection scheme.
// - Byte three bit 1 is cleared by reset before power-up width is sampled.
// - Byte three bit 0 shows current width.
// - While busy, only status reads, suspend, resume and the fail flag of a violating program or erase are taken.
// - Busy clears when operation finishes.
// - Write enable sets write latch.
// - Latch clears at reset and write-type commands.
// - Software mode needs write latch for writes.
// - Hardware mode with pin low locks writes unless quad enable is set.
module fsrb_flash_status_regs #(
  parameter OP_CYCLES = `FSRB_OP_CYCLES
) (
  input wire clock,
  input wire rst,
  input wire link_clk,
  input wire wp_n_pin,
  input wire cmd_write_enable,
  input wire cmd_write_disable,
  input wire cmd_program,
  input wire cmd_erase,
  input wire cmd_status_write,
  input wire [1:0] cmd_status_sel,
  input wire [7:0] cmd_status_data,
  input wire cmd_status_read,
  input wire [1:0] read_sel,
  input wire cmd_suspend,
  input wire cmd_resume,
  input wire cmd_enter_4byte,
  input wire cmd_exit_4byte,
  input wire op_fail,
  input wire protect_violation,
  output reg [7:0] read_data,
  output reg read_valid,
  output wire [7:0] status_byte_one,
  output wire [7:0] status_byte_two,
  output wire [7:0] status_byte_three,
  output wire quad_enable_bit,
  output wire shared_pin_is_reset,
  output wire shared_pin_is_pause,
  output wire link_clk_rise
);

  localparam ST_IDLE = 2'h0;
  localparam ST_PROG = 2'h1;
  localparam ST_ERASE = 2'h2;
  localparam ST_WRSR = 2'h3;
  // Operation length held at the counter's own width.
  localparam [15:0] OP_LEN = OP_CYCLES;

  reg [7:0] s1_reg;
  reg [7:0] s2_reg;
  reg [7:0] s3_reg;
  reg write_latch_flag_reg;
  reg erase_held_flag_reg;
  reg program_held_flag_reg;
  reg erase_fail_flag_reg;
  reg program_fail_flag_reg;
  reg current_addr_width_reg;
  reg [1:0] state_reg;
  reg [1:0] pend_sel_reg;
  reg [7:0] pend_data_reg;
  reg [15:0] count_reg;
  reg wp_meta_reg;
  reg wp_sync_reg;
  reg lclk_meta_reg;
  reg lclk_sync_reg;
  reg lclk_prev_reg;
  reg init_done_reg;

  wire busy;
  wire protect_mode_lo;
  wire protect_mode_hi;
  wire status_locked;
  wire status_write_ok;
  wire prog_start;
  wire erase_start;
  wire op_done;

  // Merge a write into a byte, keeping bits outside the writable mask.
  function [7:0] fsrb_merge;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] mask;
    begin
      fsrb_merge = (old_val & ~mask) | (new_val & mask);
    end
  endfunction

  assign busy = (state_reg != ST_IDLE);
  assign protect_mode_lo = s1_reg[`FSRB_S1_PM_LO];
  assign protect_mode_hi = s2_reg[`FSRB_S2_PM_HI];
  // Hardware lock only honours the pin while it is not a data line.
  assign status_locked = protect_mode_hi |
    (protect_mode_lo & ~wp_sync_reg & ~s2_reg[`FSRB_S2_QUAD]);
  assign status_write_ok = cmd_status_write & write_latch_flag_reg & ~status_locked & ~busy;
  assign prog_start = cmd_program & write_latch_flag_reg & ~busy;
  assign erase_start = cmd_erase & write_latch_flag_reg & ~busy;
  assign op_done = busy & (count_reg == 16'h0000);

  assign quad_enable_bit = s2_reg[`FSRB_S2_QUAD];
  assign shared_pin_is_reset = ~s2_reg[`FSRB_S2_QUAD] & s3_reg[`FSRB_S3_PIN_ROLE];
  assign shared_pin_is_pause = ~s2_reg[`FSRB_S2_QUAD] & ~s3_reg[`FSRB_S3_PIN_ROLE];
  assign link_clk_rise = lclk_sync_reg & ~lclk_prev_reg;

  assign status_byte_one = {s1_reg[7:2], write_latch_flag_reg, busy};
  assign status_byte_two = {erase_held_flag_reg, s2_reg[6:3], program_held_flag_reg, s2_reg[1:0]};
  assign status_byte_three = {s3_reg[7:5], erase_fail_flag_reg, program_fail_flag_reg,
    s3_reg[2:1], current_addr_width_reg};

  // Pin and link clock cross into the core clock through two flops.
  always @(posedge clock) begin
    if (rst) begin
      wp_meta_reg <= 1'b1;
      wp_sync_reg <= 1'b1;
      lclk_meta_reg <= 1'b0;
      lclk_sync_reg <= 1'b0;
      lclk_prev_reg <= 1'b0;
    end else begin
      wp_meta_reg <= wp_n_pin;
      wp_sync_reg <= wp_meta_reg;
      lclk_meta_reg <= link_clk;
      lclk_sync_reg <= lclk_meta_reg;
      lclk_prev_reg <= lclk_sync_reg;
    end
  end

  // Status reads are always served, even while busy.
  always @(posedge clock) begin
    if (rst) begin
      read_data <= 8'h00;
      read_valid <= 1'b0;
    end else begin
      read_valid <= cmd_status_read;
      if (cmd_status_read) begin
        case (read_sel)
          `FSRB_SEL_ONE: read_data <= status_byte_one;
          `FSRB_SEL_TWO: read_data <= status_byte_two;
          `FSRB_SEL_THREE: read_data <= status_byte_three;
          default: read_data <= 8'h00;
        endcase
      end
    end
  end

  // Embedded operation sequencer.
  always @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      count_reg <= 16'h0000;
      pend_sel_reg <= 2'h0;
      pend_data_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          count_reg <= OP_LEN - 16'h0001;
          if (status_write_ok) begin
            state_reg <= ST_WRSR;
            pend_sel_reg <= cmd_status_sel;
            pend_data_reg <= cmd_status_data;
          end else if (prog_start) begin
            state_reg <= ST_PROG;
          end else if (erase_start) begin
            state_reg <= ST_ERASE;
          end
        end
        ST_PROG, ST_ERASE: begin
          // A suspended operation holds its count until resumed.
          if (op_done) begin
            state_reg <= ST_IDLE;
          end else if (!program_held_flag_reg && !erase_held_flag_reg) begin
            count_reg <= count_reg - 16'h0001;
          end
        end
        ST_WRSR: begin
          if (op_done) begin
            state_reg <= ST_IDLE;
          end else begin
            count_reg <= count_reg - 16'h0001;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Flags and status bytes.
  always @(posedge clock) begin
    if (rst) begin
      s1_reg <= `FSRB_RESET_VAL;
      s2_reg <= `FSRB_RESET_VAL;
      s3_reg <= `FSRB_RESET_VAL;
      write_latch_flag_reg <= 1'b0;
      erase_held_flag_reg <= 1'b0;
      program_held_flag_reg <= 1'b0;
      erase_fail_flag_reg <= 1'b0;
      program_fail_flag_reg <= 1'b0;
      current_addr_width_reg <= 1'b0;
      init_done_reg <= 1'b0;
    end else begin
      // Power-up width is sampled once after reset release.
      init_done_reg <= 1'b1;
      if (!init_done_reg) begin
        current_addr_width_reg <= s3_reg[`FSRB_S3_PWRUP_AW];
      end else if (!busy && cmd_enter_4byte) begin
        current_addr_width_reg <= 1'b1;
      end else if (!busy && cmd_exit_4byte) begin
        current_addr_width_reg <= 1'b0;
      end
      if (!busy && cmd_write_enable) begin
        write_latch_flag_reg <= 1'b1;
      end else if ((!busy && cmd_write_disable) || status_write_ok || prog_start || erase_start) begin
        write_latch_flag_reg <= 1'b0;
      end
      if (cmd_suspend && state_reg == ST_ERASE) begin
        erase_held_flag_reg <= 1'b1;
      end else if (cmd_resume) begin
        erase_held_flag_reg <= 1'b0;
      end
      if (cmd_suspend && state_reg == ST_PROG) begin
        program_held_flag_reg <= 1'b1;
      end else if (cmd_resume) begin
        program_held_flag_reg <= 1'b0;
      end
      // A failure in the same cycle as a resume wins over the clear.
      if ((state_reg == ST_ERASE && op_fail) || (cmd_erase && protect_violation)) begin
        erase_fail_flag_reg <= 1'b1;
      end else if (cmd_resume) begin
        erase_fail_flag_reg <= 1'b0;
      end
      if ((state_reg == ST_PROG && op_fail) || (cmd_program && protect_violation)) begin
        program_fail_flag_reg <= 1'b1;
      end else if (cmd_resume) begin
        program_fail_flag_reg <= 1'b0;
      end
      // Written value lands when the write operation completes.
      if (state_reg == ST_WRSR && op_done) begin
        case (pend_sel_reg)
          `FSRB_SEL_ONE: s1_reg <= fsrb_merge(s1_reg, pend_data_reg, `FSRB_S1_WMASK);
          `FSRB_SEL_TWO: s2_reg <= fsrb_merge(s2_reg, pend_data_reg | (s2_reg & 8'h38),
            `FSRB_S2_WMASK);
          `FSRB_SEL_THREE: s3_reg <= fsrb_merge(s3_reg, pend_data_reg, `FSRB_S3_WMASK);
          default: s1_reg <= s1_reg;
        endcase
      end
    end
  end

endmodule // fsrb_flash_status_regs

//--- fsrb_chk_sva.sv
`timescale 1ns/1ps
module fsrb_chk #(
  parameter OP_CYCLES = 16
) (
  input wire clock,
  input wire rst,
  input wire cmd_write_enable,
  input wire cmd_write_disable,
  input wire cmd_program,
  input wire cmd_status_read,
  input wire cmd_suspend,
  input wire cmd_enter_4byte,
  input wire protect_violation,
  input wire read_valid,
  input wire [7:0] status_byte_one,
  input wire [7:0] status_byte_two,
  input wire [7:0] status_byte_three,
  input wire shared_pin_is_reset
);
  wire b = status_byte_one[0];
  wire l = status_byte_one[1];
  reg [15:0] cnt_reg;
  reg hold_reg;
  // Suspended operations run longer, so they, and those that see a protect violation, are left out of the length check.
  always @(posedge clock) begin
    if (rst || !b) begin
      cnt_reg <= 16'h0000;
      hold_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      if (cmd_suspend || protect_violation) begin
        hold_reg <= 1'b1;
      end
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_latch_set: assert property (cmd_write_enable && !b |=> l) else $error("latch not set");
  chk_latch_clear: assert property (cmd_write_disable && !b |=> !l) else $error("latch not cleared");
  chk_no_latch: assert property (!l && !b |=> !b) else $error("operation began without latch");
  chk_prog_start: assert property (cmd_program && l && !b |=> b && !l) else $error("program start wrong");
  chk_busy_ignore: assert property (b && cmd_enter_4byte && !status_byte_three[0] |=> !status_byte_three[0])
    else $error("command taken while busy");
  // The sequencer loads OP_CYCLES - 1 and stays busy down to zero, so busy lasts OP_CYCLES edges.
  chk_busy_len: assert property ($fell(b) && !hold_reg |-> cnt_reg == OP_CYCLES) else $error("busy length");
  chk_read_answer: assert property (cmd_status_read |=> read_valid) else $error("read not answered");
  chk_otp_sticky: assert property (!$past(rst) |-> ($past(status_byte_two[5:3]) & ~status_byte_two[5:3]) == 3'h0)
    else $error("lock bit cleared");
  chk_fail_set: assert property (cmd_program && protect_violation |=> status_byte_three[3]) else $error("no fail");
  chk_pin_role: assert property (shared_pin_is_reset == (status_byte_three[7] && !status_byte_two[1]))
    else $error("pin role wrong");
  cover property ($fell(b));
  cover property (cmd_status_read && b);
  cover property ($rose(status_byte_two[2]));
endmodule // fsrb_chk

//--- fsrb_host_link.sv
`timescale 1ns/1ps
module fsrb_host_link (
  input wire frame,
  output logic sck
);
  // The serial clock stands low between frames and is off the core clock grid.
  initial begin
    sck = 1'b0;
    forever begin
      wait (frame);
      #417 sck = 1'b1;
      #383 sck = 1'b0;
    end
  end
endmodule // fsrb_host_link

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam OP = 16;
  localparam WE = 12'h001, WD = 12'h002, PG = 12'h004, ER = 12'h008, SW = 12'h010, RD = 12'h020;
  localparam SU = 12'h040, RS = 12'h080, E4 = 12'h100, X4 = 12'h200, PV = 12'h800;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg wp_n = 1'b1;
  reg frame = 1'b0;
  reg [11:0] c = 12'h000;
  reg [1:0] sl = 2'h0;
  reg [7:0] dt = 8'h00;
  wire sck, rv, qe, pin_rst, pin_pause, sck_rise;
  wire [7:0] rdat, s1, s2, s3;
  integer bad_count = 0;
  integer checks_done = 0;
  integer n, i;
  initial forever #50 clock = ~clock;
  fsrb_host_link fsrb_host_link_i (.frame(frame), .sck(sck));
  fsrb_flash_status_regs #(.OP_CYCLES(OP)) fsrb_flash_status_regs_i (
    .clock(clock), .rst(rst), .link_clk(sck), .wp_n_pin(wp_n), .cmd_write_enable(c[0]),
    .cmd_write_disable(c[1]), .cmd_program(c[2]), .cmd_erase(c[3]), .cmd_status_write(c[4]),
    .cmd_status_sel(sl), .cmd_status_data(dt), .cmd_status_read(c[5]), .read_sel(sl), .cmd_suspend(c[6]),
    .cmd_resume(c[7]), .cmd_enter_4byte(c[8]), .cmd_exit_4byte(c[9]), .op_fail(c[10]),
    .protect_violation(c[11]), .read_data(rdat), .read_valid(rv), .status_byte_one(s1), .status_byte_two(s2),
    .status_byte_three(s3), .quad_enable_bit(qe), .shared_pin_is_reset(pin_rst),
    .shared_pin_is_pause(pin_pause), .link_clk_rise(sck_rise));
  task end_sim;
    begin
      if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input string name, input [7:0] exp, input [7:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        $display("ERROR %0s expected %h seen %h", name, exp, got);
        bad_count = bad_count + 1;
      end
    end
  endtask
  task go(input [11:0] v, input [1:0] s, input [7:0] d);
    begin
      @(posedge clock);
      c <= v;
      sl <= s;
      dt <= d;
      @(posedge clock);
      c <= 12'h000;
      #1;
    end
  endtask
  task idle;
    begin
      n = 0;
      while (s1[0] !== 1'b0) begin
        if (n == 60) begin
          bad_count = bad_count + 1;
          end_sim;
        end
        @(posedge clock);
        #1;
        n = n + 1;
      end
    end
  endtask
  task wr(input [1:0] s, input [7:0] d);
    begin
      go(WE, 2'h0, 8'h00);
      go(SW, s, d);
      idle;
    end
  endtask
  task rd(input [1:0] s, input [7:0] exp);
    begin
      go(RD, s, 8'h00);
      chk("read_valid", 8'h01, {7'h00, rv});
      chk("read_data", exp, rdat);
    end
  endtask
  task t_reset;
    for (i = 0; i < 4; i = i + 1) rd(i[1:0], 8'h00);
  endtask
  task t_swr;
    begin
      wr(2'h0, 8'hFF);
      rd(2'h0, 8'hFC);
      wr(2'h2, 8'hFF);
      rd(2'h2, 8'hE6);
      chk("pin_reset", 8'h01, {7'h00, pin_rst});
      @(posedge clock);
      wp_n <= 1'b0;
      repeat (3) @(posedge clock);
      go(WE, 2'h0, 8'h00);
      go(SW, 2'h0, 8'h00);
      chk("locked", 8'hFC, s1 & 8'hFD);
      @(posedge clock);
      wp_n <= 1'b1;
      go(WD, 2'h0, 8'h00);
      rd(2'h0, 8'hFC);
      wr(2'h1, 8'h02);
      chk("quad_pins", 8'h04, {5'h00, qe, pin_rst, pin_pause});
      wr(2'h1, 8'h08);
      wr(2'h1, 8'h00);
      rd(2'h1, 8'h08);
    end
  endtask
  task t_prog;
    begin
      go(PG, 2'h0, 8'h00);
      chk("busy_no_latch", 8'h00, {7'h00, s1[0]});
      go(WE, 2'h0, 8'h00);
      go(PG, 2'h0, 8'h00);
      chk("prog_start", 8'h01, {6'h00, s1[1:0]});
      go(WE, 2'h0, 8'h00);
      go(E4, 2'h0, 8'h00);
      chk("busy_ignore", 8'h00, {6'h00, s1[1], s3[0]});
      rd(2'h0, 8'hFD);
      go(SU, 2'h0, 8'h00);
      chk("prog_held", 8'h01, {7'h00, s2[2]});
      go(RS, 2'h0, 8'h00);
      chk("prog_resumed", 8'h00, {7'h00, s2[2]});
      idle;
      go(WE, 2'h0, 8'h00);
      go(ER, 2'h0, 8'h00);
      go(SU, 2'h0, 8'h00);
      chk("erase_held", 8'h01, {7'h00, s2[7]});
      go(RS, 2'h0, 8'h00);
      idle;
    end
  endtask
  task t_fail;
    begin
      go(PG | PV, 2'h0, 8'h00);
      chk("program_fail", 8'h01, {7'h00, s3[3]});
      go(ER | PV, 2'h0, 8'h00);
      chk("erase_fail", 8'h01, {7'h00, s3[4]});
      idle;
      go(E4, 2'h0, 8'h00);
      chk("addr_four", 8'h01, {7'h00, s3[0]});
      go(X4, 2'h0, 8'h00);
      chk("addr_three", 8'h00, {7'h00, s3[0]});
    end
  endtask
  task t_link;
    begin
      n = 0;
      @(posedge clock);
      frame <= 1'b1;
      for (i = 0; i < 36; i = i + 1) begin
        @(posedge clock);
        if (i == 30) frame <= 1'b0;
        #1;
        n = n + sck_rise;
      end
      chk("link_rises", 8'h04, n[7:0]);
    end
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_swr;
    t_prog;
    t_fail;
    t_link;
    end_sim;
  end
endmodule // testbench
bind fsrb_flash_status_regs fsrb_chk #(.OP_CYCLES(OP_CYCLES)) fsrb_chk_i (.clock(clock), .rst(rst),
  .cmd_write_enable(cmd_write_enable), .cmd_write_disable(cmd_write_disable), .cmd_program(cmd_program),
  .cmd_status_read(cmd_status_read), .cmd_suspend(cmd_suspend), .cmd_enter_4byte(cmd_enter_4byte),
  .protect_violation(protect_violation), .read_valid(read_valid), .status_byte_one(status_byte_one),
  .status_byte_two(status_byte_two), .status_byte_three(status_byte_three),
  .shared_pin_is_reset(shared_pin_is_reset));
